// ===== rtl/light_readout_defs.svh
// Register offsets, field positions and reset values of the light readout block
`ifndef LIGHT_READOUT_DEFS_SVH
`define LIGHT_READOUT_DEFS_SVH

// =====================================================
// Register offsets
`define OFS_FILTER_CFG      8'h0C
`define OFS_PACKAGE_CODE    8'h11
`define OFS_DEVICE_CODE     8'h12
`define OFS_STATUS          8'h13
`define OFS_CH0_LOW         8'h14
`define OFS_CH0_HIGH        8'h15
`define OFS_CH1_LOW         8'h16
`define OFS_CH1_HIGH        8'h17

// =====================================================
// Fields and reset values
`define FILTER_CFG_RESET    8'h00
`define FILTER_SEL_MSB      3
`define FILTER_SEL_LSB      0
`define PACKAGE_CODE_MSB    5
`define PACKAGE_CODE_LSB    4
`define STAT_IMMEDIATE_BIT  5
`define STAT_FILTERED_BIT   4
`define STAT_VALID_BIT      0
`define FILTER_DIRECT_MAX   4'h3
`define FILTER_STEP         6'h05
`define RUN_SATURATE        6'h3F

`endif

// ===== rtl/light_readout_pkg.sv
// Types shared by the light readout block and its serial target
package light_readout_pkg;

    // Low and high edge of a threshold window
    typedef struct packed {
        logic [15:0] low;
        logic [15:0] high;
    } window_t;

    // One conversion result of both channels
    typedef struct packed {
        logic [15:0] ch0;
        logic [15:0] ch1;
    } sample_t;

    // Register write from the serial target
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    // Serial target byte sequencer
    typedef enum logic [3:0] {
        LINK_IDLE, LINK_ADDR, LINK_ADDR_ACK, LINK_PTR, LINK_PTR_ACK,
        LINK_WDATA, LINK_WDATA_ACK, LINK_RDATA, LINK_RDATA_ACK
    } link_state_t;

endpackage

// ===== rtl/two_wire_target.sv
// Two-wire serial bus target with register pointer and auto-increment
module two_wire_target #(
    parameter logic [6:0] BUS_ADDRESS = 7'h29
) (
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_oe,
    output logic                               rd_req,
    output logic [7:0]                         rd_addr,
    input  wire logic [7:0]                    rd_data,
    output logic                               wr_en,
    output light_readout_pkg::reg_write_t      wr
);

    // =====================================================
    // Pin synchronisers
    logic scl_meta, scl_sync, scl_last;
    logic sda_meta, sda_sync, sda_last;
    light_readout_pkg::link_state_t state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic       rw;
    logic       scl_rise, scl_fall, start_seen, stop_seen;

    // Two stages before any logic looks at the pins
    always_ff @(posedge clock) begin
        if (srst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_last <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_last <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_last <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_last <= sda_sync;
        end
    end

    // Edges and bus conditions, all from the second stage onward
    assign scl_rise   = scl_sync & ~scl_last;
    assign scl_fall   = ~scl_sync & scl_last;
    assign start_seen = scl_sync & scl_last & sda_last & ~sda_sync;
    assign stop_seen  = scl_sync & scl_last & ~sda_last & sda_sync;

    // Read fetch happens on the falling edge that opens a data byte
    assign rd_req  = scl_fall & ~start_seen & ~stop_seen &
                     ((state == light_readout_pkg::LINK_ADDR_ACK & rw) |
                      state == light_readout_pkg::LINK_RDATA_ACK);
    assign rd_addr = ptr;
    assign wr_en   = scl_fall & (state == light_readout_pkg::LINK_WDATA) & (cnt == 4'h8);
    assign wr.addr = ptr;
    assign wr.data = shift;

    // =====================================================
    // Byte sequencer; sda is driven low only, on the falling edge of scl
    always_ff @(posedge clock) begin
        if (srst) begin
            state  <= light_readout_pkg::LINK_IDLE;
            cnt    <= 4'h0;
            shift  <= 8'h00;
            ptr    <= 8'h00;
            rw     <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_seen) begin
            state  <= light_readout_pkg::LINK_ADDR;
            cnt    <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop_seen) begin
            state  <= light_readout_pkg::LINK_IDLE;
            sda_oe <= 1'b0;
        end else if (scl_rise) begin
            if (state == light_readout_pkg::LINK_ADDR || state == light_readout_pkg::LINK_PTR ||
                state == light_readout_pkg::LINK_WDATA) begin
                shift <= {shift[6:0], sda_sync};
                cnt   <= cnt + 4'h1;
            end else if (state == light_readout_pkg::LINK_RDATA) begin
                cnt <= cnt + 4'h1;
            end else if (state == light_readout_pkg::LINK_RDATA_ACK && sda_sync) begin
                state <= light_readout_pkg::LINK_IDLE;   // Not acknowledged: read ends
            end
        end else if (scl_fall) begin
            unique case (state)
                light_readout_pkg::LINK_IDLE: begin
                end
                light_readout_pkg::LINK_ADDR: begin
                    if (cnt == 4'h8) begin
                        if (shift[7:1] == BUS_ADDRESS) begin
                            rw     <= shift[0];
                            sda_oe <= 1'b1;
                            state  <= light_readout_pkg::LINK_ADDR_ACK;
                        end else begin
                            state <= light_readout_pkg::LINK_IDLE;
                        end
                    end
                end
                light_readout_pkg::LINK_ADDR_ACK: begin
                    cnt <= 4'h0;
                    if (rw) begin
                        shift  <= rd_data;
                        sda_oe <= ~rd_data[7];
                        ptr    <= ptr + 8'h01;
                        state  <= light_readout_pkg::LINK_RDATA;
                    end else begin
                        sda_oe <= 1'b0;
                        state  <= light_readout_pkg::LINK_PTR;
                    end
                end
                light_readout_pkg::LINK_PTR: begin
                    if (cnt == 4'h8) begin
                        ptr    <= shift;
                        sda_oe <= 1'b1;
                        state  <= light_readout_pkg::LINK_PTR_ACK;
                    end
                end
                light_readout_pkg::LINK_PTR_ACK, light_readout_pkg::LINK_WDATA_ACK: begin
                    sda_oe <= 1'b0;
                    cnt    <= 4'h0;
                    state  <= light_readout_pkg::LINK_WDATA;
                end
                light_readout_pkg::LINK_WDATA: begin
                    if (cnt == 4'h8) begin
                        ptr    <= ptr + 8'h01;
                        sda_oe <= 1'b1;
                        state  <= light_readout_pkg::LINK_WDATA_ACK;
                    end
                end
                light_readout_pkg::LINK_RDATA: begin
                    if (cnt == 4'h8) begin
                        sda_oe <= 1'b0;
                        state  <= light_readout_pkg::LINK_RDATA_ACK;
                    end else begin
                        shift  <= {shift[6:0], 1'b0};
                        sda_oe <= ~shift[6];
                    end
                end
                light_readout_pkg::LINK_RDATA_ACK: begin
                    shift  <= rd_data;
                    sda_oe <= ~rd_data[7];
                    ptr    <= ptr + 8'h01;
                    cnt    <= 4'h0;
                    state  <= light_readout_pkg::LINK_RDATA;
                end
            endcase
        end
    end

endmodule

// ===== rtl/light_readout.sv
// Light sensor readout: persistence filter, status flags, identity and result registers
// Notes on behaviour
// - Filtered interrupt rises after the set count of consecutive out-of-window channel 0 results.
// - Immediate interrupt ignores the filter count; the filter acts on the filtered path only.
// - Filter configuration register is zero after reset.
// - Count code 0000 raises the filtered interrupt at every cycle end, whatever the result.
// - Count code 0001 raises it on any single out-of-window result.
// - Codes 2 and 3 need 2 and 3 results; codes 4..15 need 5..60, step five.
// - Package register holds a fixed two-bit code in bits 5:4, others reserved.
// - Identity register returns a fixed eight-bit code that never changes.
// - Status bit 5 shows an immediate interrupt condition occurred; status is read-only.
// - Status bit 4 shows the filtered interrupt is being asserted.
// - Status bit 0 sets after a full cycle of both channels since measurement enable.
// - Each channel result is two bytes, low first: ch0 at 0x14/0x15, ch1 at 0x16/0x17.
// - Reading a low byte latches the upper byte; the upper read returns that copy.
// - Each channel has its own upper-byte copy, taken only by its own low read.
// - Channel 0 outside the immediate window raises the immediate interrupt at cycle end.
// - Status always readable; interrupt pin driven only when its enable is set.
// - Interrupt flags hold until the clear command, which removes both of them; the valid flag stays.
`include "light_readout_defs.svh"

module light_readout #(
    parameter logic [6:0] BUS_ADDRESS  = 7'h29,
    parameter logic [1:0] PACKAGE_CODE = 2'h2,     // Arbitrary value
    parameter logic [7:0] DEVICE_CODE  = 8'hA5,    // Arbitrary value
    parameter int         RUN_WIDTH    = 6
) (
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               sda_out,
    output logic                               sda_oe,
    output logic                               int_out,
    output logic                               int_oe,
    input  wire logic                          cycle_done,
    input  wire light_readout_pkg::sample_t    sample,
    input  wire light_readout_pkg::window_t    filter_window,
    input  wire light_readout_pkg::window_t    immediate_window,
    input  wire logic                          light_measure_enable,
    input  wire logic                          filtered_irq_enable,
    input  wire logic                          immediate_irq_enable,
    input  wire logic                          irq_clear
);

    // =====================================================
    // Elaboration check: the run counter must reach 60
    if (RUN_WIDTH != 6) begin : g_width_check
        $error("RUN_WIDTH must be 6");
    end

    logic                           rd_req;
    logic [7:0]                     rd_addr;
    logic [7:0]                     rd_data;
    logic                           wr_en;
    light_readout_pkg::reg_write_t  wr;
    logic [3:0]                     filter_count_select;
    light_readout_pkg::sample_t     ch_count;
    logic [7:0]                     ch0_shadow;
    logic [7:0]                     ch1_shadow;
    logic [5:0]                     run;
    logic [5:0]                     next_run;
    logic [5:0]                     need;
    logic                           filter_out;
    logic                           immediate_out;
    logic                           filtered_set;
    logic                           filtered_irq_flag;
    logic                           immediate_irq_flag;
    logic                           result_valid_flag;

    // Both pins are open drain: only the enable ever changes
    assign sda_out = 1'b0;
    assign int_out = 1'b0;

    // =====================================================
    // Serial target
    two_wire_target #(
        .BUS_ADDRESS (BUS_ADDRESS)
    ) u_target (
        .clock   (clock),
        .srst    (srst),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .sda_oe  (sda_oe),
        .rd_req  (rd_req),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .wr_en   (wr_en),
        .wr      (wr)
    );

    // =====================================================
    // Filter configuration; upper bits are not stored and read zero
    always_ff @(posedge clock) begin
        if (srst) begin
            filter_count_select <= 4'(`FILTER_CFG_RESET);
        end else if (wr_en && wr.addr == `OFS_FILTER_CFG) begin
            filter_count_select <= wr.data[`FILTER_SEL_MSB:`FILTER_SEL_LSB];
        end
    end

    // Required run length per code: direct up to 3, then steps of five
    always_comb begin
        if (filter_count_select <= `FILTER_DIRECT_MAX) begin
            need = {2'h0, filter_count_select};
        end else begin
            need = 6'((filter_count_select - `FILTER_DIRECT_MAX) * `FILTER_STEP);
        end
    end

    // =====================================================
    // Window comparisons against the fresh channel 0 result
    assign filter_out    = (sample.ch0 < filter_window.low) || (sample.ch0 > filter_window.high);
    assign immediate_out = (sample.ch0 < immediate_window.low) || (sample.ch0 > immediate_window.high);

    // Saturating run count so a long excursion cannot wrap back below the need
    assign next_run = !filter_out ? 6'h00 :
                      (run == `RUN_SATURATE) ? run : run + 6'h01;
    assign filtered_set = cycle_done &&
                          (filter_count_select == 4'h0 ||
                           (filter_out && next_run >= need));

    // Run counter; a cycle end wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            run <= 6'h00;
        end else if (cycle_done) begin
            run <= next_run;
        end else if (irq_clear) begin
            run <= 6'h00;
        end
    end

    // =====================================================
    // Interrupt flags: set wins over clear
    always_ff @(posedge clock) begin
        if (srst) begin
            filtered_irq_flag  <= 1'b0;
            immediate_irq_flag <= 1'b0;
        end else begin
            if (filtered_set) begin
                filtered_irq_flag <= 1'b1;
            end else if (irq_clear) begin
                filtered_irq_flag <= 1'b0;
            end
            if (cycle_done && immediate_out) begin
                immediate_irq_flag <= 1'b1;
            end else if (irq_clear) begin
                immediate_irq_flag <= 1'b0;
            end
        end
    end

    // Valid follows the enable; dropping the enable forgets it
    always_ff @(posedge clock) begin
        if (srst) begin
            result_valid_flag <= 1'b0;
        end else if (!light_measure_enable) begin
            result_valid_flag <= 1'b0;
        end else if (cycle_done) begin
            result_valid_flag <= 1'b1;
        end
    end

    // Pin pulls low only through an enabled source
    always_ff @(posedge clock) begin
        if (srst) begin
            int_oe <= 1'b0;
        end else begin
            int_oe <= (filtered_irq_flag && filtered_irq_enable) ||
                      (immediate_irq_flag && immediate_irq_enable);
        end
    end

    // =====================================================
    // Result registers, loaded whole at each cycle end
    always_ff @(posedge clock) begin
        if (srst) begin
            ch_count <= '0;
        end else if (cycle_done) begin
            ch_count <= sample;
        end
    end

    // Upper-byte copies, one per channel, taken by its own low read
    always_ff @(posedge clock) begin
        if (srst) begin
            ch0_shadow <= 8'h00;
            ch1_shadow <= 8'h00;
        end else if (rd_req) begin
            if (rd_addr == `OFS_CH0_LOW) begin
                ch0_shadow <= ch_count.ch0[15:8];
            end
            if (rd_addr == `OFS_CH1_LOW) begin
                ch1_shadow <= ch_count.ch1[15:8];
            end
        end
    end

    // =====================================================
    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_data = 8'h00;
        unique case (rd_addr)
            `OFS_FILTER_CFG:   rd_data = {4'h0, filter_count_select};
            `OFS_PACKAGE_CODE: rd_data[`PACKAGE_CODE_MSB:`PACKAGE_CODE_LSB] = PACKAGE_CODE;
            `OFS_DEVICE_CODE:  rd_data = DEVICE_CODE;
            `OFS_STATUS: begin
                rd_data[`STAT_IMMEDIATE_BIT] = immediate_irq_flag;
                rd_data[`STAT_FILTERED_BIT]  = filtered_irq_flag;
                rd_data[`STAT_VALID_BIT]     = result_valid_flag;
            end
            `OFS_CH0_LOW:  rd_data = ch_count.ch0[7:0];
            `OFS_CH0_HIGH: rd_data = ch0_shadow;
            `OFS_CH1_LOW:  rd_data = ch_count.ch1[7:0];
            `OFS_CH1_HIGH: rd_data = ch1_shadow;
            default:       rd_data = 8'h00;
        endcase
    end

    // =====================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    cfg_reset_a: assert property ($fell(srst) |-> filter_count_select == 4'h0)
        else $error("filter configuration not zero after reset");
    code_zero_a: assert property (cycle_done && filter_count_select == 4'h0 |=> filtered_irq_flag)
        else $error("code zero did not raise filtered interrupt");
    code_one_a: assert property (cycle_done && filter_count_select == 4'h1 && filter_out
                                 |=> filtered_irq_flag)
        else $error("single out-of-window result did not raise filtered interrupt");
    run_short_a: assert property (cycle_done && filter_count_select != 4'h0 && !filtered_irq_flag &&
                                  (!filter_out || next_run < need) |=> !filtered_irq_flag)
        else $error("filtered interrupt before the run was long enough");
    code_max_a: assert property (filter_count_select == 4'hF |-> need == 6'h3C)
        else $error("top code does not need sixty results");
    run_fire_a: assert property (cycle_done && filter_out && run == need - 6'h01 && need != 6'h00
                                 |=> filtered_irq_flag)
        else $error("filtered interrupt missing after the full run");
    run_reset_a: assert property (cycle_done && !filter_out |=> run == 6'h00)
        else $error("run counter kept counting over an in-window result");
    immediate_a: assert property (cycle_done && immediate_out |=> immediate_irq_flag [*2]
                                  or (immediate_irq_flag ##1 !immediate_irq_flag && $past(irq_clear)))
        else $error("immediate interrupt not raised at cycle end");
    clear_a: assert property (irq_clear && !cycle_done |=> !filtered_irq_flag && !immediate_irq_flag
                              && run == 6'h00)
        else $error("clear left an interrupt pending");
    hold_a: assert property (filtered_irq_flag && !irq_clear |=> filtered_irq_flag)
        else $error("filtered flag dropped without clear");
    pin_a: assert property ((!filtered_irq_enable && !immediate_irq_enable) [*2] |-> !int_oe)
        else $error("interrupt pin driven while disabled");
    pin_on_a: assert property (filtered_irq_flag && filtered_irq_enable |=> int_oe)
        else $error("enabled filtered interrupt not on pin");
    valid_a: assert property (cycle_done && light_measure_enable ##1 light_measure_enable
                              |-> result_valid_flag)
        else $error("valid flag not set after a full cycle");
    // Consecutive byte fetches in one read frame are nine bit times, 72 clocks, apart
    shadow_a: assert property (rd_req && rd_addr == `OFS_CH0_LOW ##72 rd_req && rd_addr == `OFS_CH0_HIGH
                               |-> rd_data == $past(ch_count.ch0[15:8], 72))
        else $error("upper byte not the latched copy");
    shadow_keep_a: assert property (rd_req && rd_addr == `OFS_CH0_LOW |=> $stable(ch1_shadow))
        else $error("channel 1 copy taken by a channel 0 read");
    ident_a: assert property (rd_addr == `OFS_DEVICE_CODE |-> rd_data == DEVICE_CODE)
        else $error("identity register changed");
    status_a: assert property (rd_addr == `OFS_STATUS |-> rd_data[4] == filtered_irq_flag &&
                               rd_data[5] == immediate_irq_flag && rd_data[7:6] == 2'h0)
        else $error("status register does not match flags");

    filtered_fire_c: cover property (filter_count_select == 4'h4 && filtered_set);
    shadow_read_c:   cover property (rd_req && rd_addr == `OFS_CH0_LOW ##[1:300] rd_req && rd_addr == `OFS_CH0_HIGH);
    clear_race_c:    cover property (irq_clear && filtered_set);
    cfg_write_c:     cover property (wr_en && wr.addr == `OFS_FILTER_CFG);

endmodule

// ===== dv/serial_host.sv
// Two-wire bus host model that writes and reads the readout registers
module serial_host #(
    parameter logic [6:0] ADDR = 7'h29
) (
    input  wire logic clock,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up holds the wire high unless a party pulls it low
    wire line = !(sda_low || sda_oe);
    // Bus idles high, so the link clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start (b=1) or stop (b=0); data moves two clocks after a fall, clear of the sync delay
    task automatic frame_mark(input logic a, input logic b);
        repeat (2) @(posedge clock);
        sda_low <= a;
        repeat (2) @(posedge clock);
        scl <= 1'b1;
        repeat (4) @(posedge clock);
        sda_low <= b;
        repeat (4) @(posedge clock);
        scl <= !b;
    endtask
    // One 80 ns bit; the wire is sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(posedge clock);
        sda_low <= !b;
        repeat (2) @(posedge clock);
        scl <= 1'b1;
        repeat (4) @(posedge clock);
        r = line;
        scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, a);
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] val);
        logic [7:0] rx;
        frame_mark(1'b0, 1'b1);
        xfer({ADDR, 1'b0}, 1'b1, rx);
        xfer(ofs, 1'b1, rx);
        xfer(val, 1'b1, rx);
        frame_mark(1'b1, 1'b0);
    endtask
    // Pointer write, repeated start, then n bytes in one run with the last one refused
    task automatic read_regs(input logic [7:0] ofs, input int n, output logic [31:0] got);
        logic [7:0] rx;
        frame_mark(1'b0, 1'b1);
        xfer({ADDR, 1'b0}, 1'b1, rx);
        xfer(ofs, 1'b1, rx);
        frame_mark(1'b0, 1'b1);
        xfer({ADDR, 1'b1}, 1'b1, rx);
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, i == n - 1, rx);
            got[8*i+:8] = rx;
        end
        frame_mark(1'b1, 1'b0);
    endtask
endmodule

// ===== dv/light_readout_tb_top.sv
// Self-checking bench for the light readout block
module light_readout_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] PKG = 2'h2;  // Arbitrary value
    localparam logic [7:0] DEV = 8'hA5; // Arbitrary value
    logic        clock, srst = 1'b1, scl, sda_low, sda_oe, int_oe;
    logic        cycle_done = 1'b0, irq_clear = 1'b0, imm_en = 1'b1, filt_en = 1'b1, meas_en = 1'b1;
    logic [31:0] sample = 32'h0, imm_win = 32'h0000_FFFF, got;
    int          num_errors = 0, comparisons = 0, cycles = 0;
    serial_host host (.clock(clock), .sda_oe(sda_oe), .scl(scl), .sda_low(sda_low));
    light_readout #(.PACKAGE_CODE(PKG), .DEVICE_CODE(DEV)) DUT (
        .clock(clock), .srst(srst), .scl_in(scl), .sda_in(!(sda_low || sda_oe)), .sda_out(), .sda_oe(sda_oe),
        .int_out(), .int_oe(int_oe), .cycle_done(cycle_done), .sample(sample), .filter_window(32'h0100_0200),
        .immediate_window(imm_win), .light_measure_enable(meas_en), .filtered_irq_enable(filt_en),
        .immediate_irq_enable(imm_en), .irq_clear(irq_clear));
    // ====================
    // Helpers
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Flags need two edges to reach the pin, so each pulse waits three
    task automatic conv(input int n, input logic [31:0] s);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            cycle_done <= 1'b1;
            sample <= s;
            @(posedge clock);
            cycle_done <= 1'b0;
            repeat (3) @(posedge clock);
        end
    endtask
    task automatic clear();
        @(posedge clock);
        irq_clear <= 1'b1;
        @(posedge clock);
        irq_clear <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ====================
    // Clock, hang guard and main sequence
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ====================
    // Scenarios
    task automatic test_identity();
        host.read_regs(8'h0C, 4, got);
        check(got, 32'h0);
        host.read_regs(8'h11, 3, got);
        check(got[23:0], {8'h00, DEV, 2'b00, PKG, 4'h0});
        $display("identity test done");
    endtask
    // Every code but 0: a run one short, broken by an in-window result, must not fire; code 0 must
    task automatic test_filter();
        int need;
        for (int c = 0; c < 16; c++) begin
            need = (c < 4) ? c : 5 * (c - 3);
            host.write_reg(8'h0C, {4'h0, c[3:0]});
            clear();
            conv(need - 1, 32'h0300_0000);
            conv(1, 32'h0150_0000);
            conv(need - 1, 32'h0300_0000);
            check(int_oe, c == 0);
            conv(1, 32'h0300_0000);
            check(int_oe, 1'b1);
        end
        host.read_regs(8'h13, 1, got);
        check(got[7:0], 8'h11);
        $display("filter test done");
    endtask
    // Both enables off keep the pin quiet; dropping the measure enable forgets valid
    task automatic test_immediate();
        clear();
        @(posedge clock);
        imm_en <= 1'b0;
        filt_en <= 1'b0;
        imm_win <= 32'h0100_0200;
        conv(1, 32'h0300_0000);
        check(int_oe, 1'b0);
        host.read_regs(8'h13, 1, got);
        check(got[7:0], 8'h21);
        imm_en <= 1'b1;
        filt_en <= 1'b1;
        repeat (3) @(posedge clock);
        check(int_oe, 1'b1);
        clear();
        host.read_regs(8'h13, 1, got);
        check(got[7:0], 8'h01);
        meas_en <= 1'b0;
        host.read_regs(8'h13, 1, got);
        check(got[7:0], 8'h00);
        meas_en <= 1'b1;
        $display("immediate test done");
    endtask
    // Upper bytes must come from the shadow, not from the newer result
    task automatic test_results();
        conv(1, 32'h1234_5678);
        host.read_regs(8'h14, 1, got);
        check(got[7:0], 8'h34);
        conv(1, 32'hABCD_EF01);
        host.read_regs(8'h15, 3, got);
        check(got[23:0], 24'hEF0112);
        host.read_regs(8'h14, 4, got);
        check(got, 32'hEF01_ABCD);
        $display("result test done");
    endtask
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        repeat (3) @(posedge clock);
        test_identity();
        test_filter();
        test_immediate();
        test_results();
        tally_and_finish();
    end
endmodule
